// *** emp_pkg.sv ***
// Purpose: Shared constants and types for the off-chip memory port.
// Assumes: 10 MHz system clock; register port with 8-bit addresses.
// Notes:   Every offset, field position, reset value and count lives here.
package emp_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] EMP_PAGE_ADDR = 8'haa;  // Page select
	localparam logic [7:0] EMP_CFG_ADDR  = 8'hb2;  // Memory configuration

	// Reset values
	localparam logic [7:0] EMP_PAGE_RST = 8'h00;   // Page 0
	localparam logic [7:0] EMP_CFG_RST  = 8'h03;   // Muxed, internal, wide ALE

	// Configuration field positions
	localparam int EMP_MUX_BIT  = 4;               // 0 muxed, 1 separate
	localparam int EMP_MODE_LSB = 2;               // Two-bit memory mode
	localparam int EMP_ALE_LSB  = 0;               // Two-bit latch pulse width
	localparam logic [7:0] EMP_CFG_MASK = 8'h1f;   // Bits 7:5 read as zero

	// Port 1 control lane positions
	localparam int EMP_ALE_PIN = 5;                // Address latch strobe
	localparam int EMP_RD_PIN  = 6;                // Read strobe, low active
	localparam int EMP_WR_PIN  = 7;                // Write strobe, low active

	// Top of the on-chip window in split modes (8 kB)
	localparam logic [15:0] EMP_ONCHIP_LIMIT = 16'h2000;

	// Timing: figures in ns, counts in 100 ns cycles
	localparam int EMP_CLK_MHZ   = 10;             // System clock rate
	localparam int EMP_STROBE_NS = 400;            // Least strobe low time
	localparam int EMP_HOLD_NS   = 100;            // Least address hold
	localparam int EMP_STROBE_CYC = (EMP_STROBE_NS * EMP_CLK_MHZ + 999) / 1000;
	localparam int EMP_HOLD_CYC   = (EMP_HOLD_NS * EMP_CLK_MHZ + 999) / 1000;
	localparam int EMP_SYNC_CYC   = 4;             // Pin sampling latency

	// Memory mode field encodings
	typedef enum logic [1:0] {
		EMP_MODE_INT   = 2'b00,                    // On-chip only
		EMP_MODE_SPLIT = 2'b01,                    // Split, no bank select
		EMP_MODE_BANK  = 2'b10,                    // Split with bank select
		EMP_MODE_EXT   = 2'b11                     // Off-chip only
	} emp_mode_t;

	// Access sequencer states, one-hot
	typedef enum logic [4:0] {
		EMP_IDLE = 5'b00001,                       // Pins belong to the port
		EMP_ALE  = 5'b00010,                       // Low address, latch high
		EMP_HOLD = 5'b00100,                       // Low address held
		EMP_STRB = 5'b01000,                       // Read or write strobe low
		EMP_DONE = 5'b10000                        // Pins handed back
	} emp_state_t;

endpackage

// *** emp_offchip_port.sv ***
// Purpose: Off-chip memory port that borrows ports 1 to 3, and port 4 in separate mode, for each off-chip move.
// Assumes: One 10 MHz clock; core raises acc_start for one cycle per move.
// Notes:   Output mode (open-drain or push-pull) is set outside this block.
// What this block does
// - Off-chip accesses appear on ports one to four
// - Pins claimed only during off-chip moves
// - Afterwards pins return to latch or crossbar
// - Input lanes have drivers off during read strobe
// - Output mode stays with port mode registers
// - Multiplexed and separate address/data modes offered
// - Short moves take upper byte from page
// - Page N covers N*256 to N*256+255
// - Page register 8-bit, offset 0xaa, resets zero
// - All eight page bits read and write
// - Mux select 0 muxed, 1 separate
// - Mode field picks internal, split, bank, external
// - Split without bank uses port 2 latch
// - Low config bits set latch pulse width
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module emp_offchip_port
	import emp_pkg::*;
#(
	parameter int STROBE_CYCLES = EMP_STROBE_CYC  // Strobe low cycles
) (
	input  wire logic        clk,          // 10 MHz system clock
	input  wire logic        rst,          // Async reset, high
	input  wire logic [7:0]  reg_addr,     // Register address
	input  wire logic [7:0]  reg_wdata,    // Register write data
	input  wire logic        reg_wr,       // Register write strobe
	input  wire logic        reg_rd,       // Register read strobe
	output logic      [7:0]  reg_rdata,    // Read data, cycle after
	input  wire logic        acc_start,    // Core starts a move
	input  wire logic        acc_write,    // 1 write, 0 read
	input  wire logic        acc_wide,     // 1 pointer form, 0 short
	input  wire logic [15:0] acc_addr,     // Address, low byte if short
	input  wire logic [7:0]  acc_wdata,    // Write data
	output logic             acc_busy,     // Move in progress
	output logic             acc_done,     // Move finished pulse
	output logic             acc_onchip,   // Done move was on-chip
	output logic      [7:0]  acc_rdata,    // Off-chip read data
	input  wire logic [7:0]  p1_port_out,  // Port 1 latch/crossbar level
	input  wire logic [7:0]  p1_port_oe,   // Port 1 latch/crossbar enable
	input  wire logic [7:0]  p2_port_out,  // Port 2 latch/crossbar level
	input  wire logic [7:0]  p2_port_oe,   // Port 2 latch/crossbar enable
	input  wire logic [7:0]  p3_port_out,  // Port 3 latch/crossbar level
	input  wire logic [7:0]  p3_port_oe,   // Port 3 latch/crossbar enable
	input  wire logic [7:0]  p4_port_out,  // Port 4 latch/crossbar level
	input  wire logic [7:0]  p4_port_oe,   // Port 4 latch/crossbar enable
	input  wire logic [7:0]  p3_pin_in,    // Port 3 pad levels
	input  wire logic [7:0]  p4_pin_in,    // Port 4 pad levels
	output logic      [7:0]  p1_out,       // Port 1 pad level
	output logic      [7:0]  p1_oe,        // Port 1 pad enable
	output logic      [7:0]  p2_out,       // Port 2 pad level
	output logic      [7:0]  p2_oe,        // Port 2 pad enable
	output logic      [7:0]  p3_out,       // Port 3 pad level
	output logic      [7:0]  p3_oe,        // Port 3 pad enable
	output logic      [7:0]  p4_out,       // Port 4 pad level
	output logic      [7:0]  p4_oe         // Port 4 pad enable
);

	// Strobe must outlast the pad sampling chain or reads go stale
	if (STROBE_CYCLES < EMP_SYNC_CYC || STROBE_CYCLES > 15) begin : g_chk
		$error("STROBE_CYCLES out of range 4..15");
	end
	localparam logic [3:0] STRB_LD = 4'(STROBE_CYCLES - 1);
	localparam logic [3:0] HOLD_LD = 4'(EMP_HOLD_CYC - 1);

	// Registers seen by software
	logic [7:0] page_number;               // Upper byte for short moves
	logic [7:0] cfg;                       // Memory configuration
	logic [7:0] next_page_number;          // Next page value
	logic [7:0] next_cfg;                  // Next configuration
	logic [7:0] next_reg_rdata;            // Next read data
	logic       mux_mode_select;           // 1 separate lanes
	emp_mode_t  memory_mode_select;        // Routing mode
	logic [1:0] latch_pulse_width;         // Latch strobe width - 1

	assign mux_mode_select    = cfg[EMP_MUX_BIT];
	assign memory_mode_select = emp_mode_t'(cfg[EMP_MODE_LSB +: 2]);
	assign latch_pulse_width  = cfg[EMP_ALE_LSB +: 2];

	// Register decode; unmapped reads return zero
	always_comb begin
		next_page_number = page_number;
		next_cfg         = cfg;
		next_reg_rdata   = 8'h00;
		if (reg_wr && reg_addr == EMP_PAGE_ADDR) begin
			next_page_number = reg_wdata;
		end else if (reg_wr && reg_addr == EMP_CFG_ADDR) begin
			next_cfg = reg_wdata & EMP_CFG_MASK;
		end
		if (reg_rd && reg_addr == EMP_PAGE_ADDR) begin
			next_reg_rdata = page_number;
		end else if (reg_rd && reg_addr == EMP_CFG_ADDR) begin
			next_reg_rdata = cfg;
		end
	end

	// Register storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_number <= EMP_PAGE_RST;
			cfg         <= EMP_CFG_RST;
			reg_rdata   <= 8'h00;
		end else begin
			page_number <= next_page_number;
			cfg         <= next_cfg;
			reg_rdata   <= next_reg_rdata;
		end
	end

	// Pad sampling: three flops, accept when stages two and three agree
	logic [15:0] pin_s1;                   // First stage, only feeds s2
	logic [15:0] pin_s2;                   // Second stage
	logic [15:0] pin_s3;                   // Third stage
	logic [15:0] pin_filt;                 // Accepted pad levels
	logic [15:0] next_pin_filt;            // Next accepted levels

	always_comb begin
		next_pin_filt = pin_filt;
		for (int i = 0; i < 16; i++) begin
			if (pin_s2[i] == pin_s3[i]) begin
				next_pin_filt[i] = pin_s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1   <= 16'h0000;
			pin_s2   <= 16'h0000;
			pin_s3   <= 16'h0000;
			pin_filt <= 16'h0000;
		end else begin
			pin_s1   <= {p4_pin_in, p3_pin_in};
			pin_s2   <= pin_s1;
			pin_s3   <= pin_s2;
			pin_filt <= next_pin_filt;
		end
	end

	// Access sequencer state
	emp_state_t  state, next_state;        // Sequencer state
	logic [3:0]  cnt, next_cnt;            // Phase down-counter
	logic [15:0] addr_q, next_addr_q;      // Effective address
	logic [7:0]  wdata_q, next_wdata_q;    // Write data held
	logic        write_q, next_write_q;    // Direction held
	logic        next_done, next_onchip;   // Completion pulse
	logic [7:0]  next_rdata;               // Captured read data
	logic [7:0]  hi_byte;                  // Upper address byte
	logic [15:0] eff_addr;                 // Effective address now
	logic        offchip;                  // Request goes to pads

	// Upper byte and routing of a new request
	always_comb begin
		if (acc_wide) begin
			hi_byte = acc_addr[15:8];
		end else if (memory_mode_select == EMP_MODE_SPLIT) begin
			hi_byte = p2_port_out;
		end else begin
			hi_byte = page_number;
		end
		eff_addr = {hi_byte, acc_addr[7:0]};
		case (memory_mode_select)
			EMP_MODE_INT: offchip = 1'b0;
			EMP_MODE_EXT: offchip = 1'b1;
			default:      offchip = eff_addr >= EMP_ONCHIP_LIMIT;
		endcase
	end

	// Next state; muxed moves pulse the latch before data
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_addr_q  = addr_q;
		next_wdata_q = wdata_q;
		next_write_q = write_q;
		next_done    = 1'b0;
		next_onchip  = 1'b0;
		next_rdata   = acc_rdata;
		case (state)
			EMP_IDLE: begin
				if (acc_start && offchip) begin
					next_addr_q  = eff_addr;
					next_wdata_q = acc_wdata;
					next_write_q = acc_write;
					if (!mux_mode_select) begin
						next_state = EMP_ALE;
						next_cnt   = {2'b00, latch_pulse_width};
					end else begin
						next_state = EMP_STRB;
						next_cnt   = STRB_LD;
					end
				end else if (acc_start) begin
					next_done   = 1'b1;  // On-chip RAM serves it
					next_onchip = 1'b1;
				end
			end
			EMP_ALE: begin
				if (cnt == 4'h0) begin
					next_state = EMP_HOLD;
					next_cnt   = HOLD_LD;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMP_HOLD: begin
				if (cnt == 4'h0) begin
					next_state = EMP_STRB;
					next_cnt   = STRB_LD;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMP_STRB: begin
				if (cnt == 4'h0) begin
					next_state = EMP_DONE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMP_DONE: begin
				// Filtered pads trail the strobe by four edges, so the
				// read byte is only settled once the strobe has ended
				next_state = EMP_IDLE;
				next_done  = 1'b1;
				if (!write_q) begin
					next_rdata = mux_mode_select ? pin_filt[15:8]
					                             : pin_filt[7:0];
				end
			end
			default: next_state = EMP_IDLE;
		endcase
	end

	// Pads: port values unless claimed; output modes untouched
	logic       next_claim;                // Pads owned next cycle
	logic [7:0] n_p1o, n_p1e, n_p2o, n_p2e;  // Next port 1/2 pads
	logic [7:0] n_p3o, n_p3e, n_p4o, n_p4e;  // Next port 3/4 pads
	logic       n_strb;                    // Strobe phase next

	always_comb begin
		next_claim = next_state inside {EMP_ALE, EMP_HOLD, EMP_STRB};
		n_strb = next_state == EMP_STRB;
		n_p1o = p1_port_out;
		n_p1e = p1_port_oe;
		n_p2o = p2_port_out;
		n_p2e = p2_port_oe;
		n_p3o = p3_port_out;
		n_p3e = p3_port_oe;
		n_p4o = p4_port_out;
		n_p4e = p4_port_oe;
		if (next_claim) begin
			n_p1o[EMP_RD_PIN] = !(n_strb && !next_write_q);
			n_p1e[EMP_RD_PIN] = 1'b1;
			n_p1o[EMP_WR_PIN] = !(n_strb && next_write_q);
			n_p1e[EMP_WR_PIN] = 1'b1;
			n_p2o = next_addr_q[15:8];
			n_p2e = 8'hff;
			if (mux_mode_select) begin
				n_p3o = next_addr_q[7:0];
				n_p3e = 8'hff;
				n_p4o = next_wdata_q;
				n_p4e = next_write_q ? 8'hff : 8'h00;
			end else begin
				n_p1o[EMP_ALE_PIN] = next_state == EMP_ALE;
				n_p1e[EMP_ALE_PIN] = 1'b1;
				n_p3o = n_strb ? next_wdata_q : next_addr_q[7:0];
				n_p3e = (n_strb && !next_write_q) ? 8'h00 : 8'hff;
			end
		end
	end

	logic claim;                           // Pads owned now

	// Sequencer and pad registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= EMP_IDLE;
			cnt <= 4'h0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			write_q <= 1'b0;
			acc_done <= 1'b0;
			acc_onchip <= 1'b0;
			acc_rdata <= 8'h00;
			claim <= 1'b0;
			{p1_out, p1_oe, p2_out, p2_oe} <= 32'h00000000;
			{p3_out, p3_oe, p4_out, p4_oe} <= 32'h00000000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			write_q <= next_write_q;
			acc_done <= next_done;
			acc_onchip <= next_onchip;
			acc_rdata <= next_rdata;
			claim <= next_claim;
			{p1_out, p1_oe, p2_out, p2_oe} <= {n_p1o, n_p1e, n_p2o, n_p2e};
			{p3_out, p3_oe, p4_out, p4_oe} <= {n_p3o, n_p3e, n_p4o, n_p4e};
		end
	end

	// Busy while a move runs; core holds off new starts
	assign acc_busy = state != EMP_IDLE;

	// Latch pulse length counter, read only by checks
	logic [2:0] ale_len;                   // Cycles latch strobe high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ale_len <= 3'h0;
		end else begin
			ale_len <= (claim && p1_out[EMP_ALE_PIN]) ? ale_len + 3'h1 : 3'h0;
		end
	end

	a_pins_released: assert property (@(posedge clk) disable iff (rst)
		!next_claim |=> (p2_out == $past(p2_port_out)
		                 && p4_oe == $past(p4_port_oe)))
		else $error("pads not returned to port");

	a_read_lanes_off: assert property (@(posedge clk) disable iff (rst)
		(claim && !p1_out[EMP_RD_PIN])
		|-> (mux_mode_select ? p4_oe == 8'h00 : p3_oe == 8'h00))
		else $error("input lane driven during read");

	a_claim_only_move: assert property (@(posedge clk) disable iff (rst)
		claim |-> (state inside {EMP_ALE, EMP_HOLD, EMP_STRB}) && p2_oe == 8'hff)
		else $error("pads claimed outside a move");

	a_page_upper: assert property (@(posedge clk) disable iff (rst)
		(state == EMP_IDLE && acc_start && !acc_wide
		 && memory_mode_select inside {EMP_MODE_BANK, EMP_MODE_EXT} && offchip)
		|=> addr_q == {$past(page_number), $past(acc_addr[7:0])})
		else $error("short move upper byte not from page");

	a_split_latch: assert property (@(posedge clk) disable iff (rst)
		(state == EMP_IDLE && acc_start && !acc_wide && offchip
		 && memory_mode_select == EMP_MODE_SPLIT)
		|=> addr_q[15:8] == $past(p2_port_out))
		else $error("split move upper byte not from port 2");

	a_page_hold: assert property (@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == EMP_PAGE_ADDR) |=> page_number == $past(reg_wdata))
		else $error("page write lost");

	a_ale_width: assert property (@(posedge clk) disable iff (rst)
		$fell(p1_out[EMP_ALE_PIN]) && $past(claim)
		|-> ale_len == {1'b0, latch_pulse_width} + 3'h1)
		else $error("latch pulse width wrong");

	a_addr_first: assert property (@(posedge clk) disable iff (rst)
		(claim && !mux_mode_select && p1_oe[EMP_ALE_PIN]
		 && p1_out[EMP_ALE_PIN])
		|-> (p3_out == addr_q[7:0] && p3_oe == 8'hff
		     && p1_out[EMP_RD_PIN] && p1_out[EMP_WR_PIN]))
		else $error("muxed address not ahead of data");

	a_onchip_done: assert property (@(posedge clk) disable iff (rst)
		(state == EMP_IDLE && acc_start && !offchip)
		|=> acc_done && acc_onchip && !claim)
		else $error("on-chip move not finished in one cycle");

endmodule

// *** emp_sram_model.sv ***
// Purpose: Behavioural off-chip SRAM sitting behind ports 1 to 4.
// Assumes: Strobes low on port 1 bits 6/7, latch strobe high on bit 5.
// Notes:   Released lanes toggle every cycle so stale data never passes.
`timescale 1ns/1ns
module emp_sram_model (
	input  wire logic       clk,       // System clock
	input  wire logic [7:0] p1_out,    // Control lanes
	input  wire logic [7:0] p1_oe,     // Control enables
	input  wire logic [7:0] p2_out,    // Address high lanes
	input  wire logic [7:0] p3_out,    // Address low or shared lanes
	input  wire logic [7:0] p3_oe,     // Shared lane enables
	input  wire logic [7:0] p4_out,    // Separate data lanes
	input  wire logic [7:0] p4_oe,     // Separate data enables
	output logic      [7:0] p3_pin_in, // Level seen on port 3 pads
	output logic      [7:0] p4_pin_in  // Level seen on port 4 pads
);
	logic [7:0]  mem [0:65535];  // Storage
	logic [7:0]  lo_lat;         // Low address caught by latch strobe
	logic        latched = 1'b0; // Latch strobe seen in this access
	logic [7:0]  park = 8'h5a;   // Pattern on undriven lanes
	logic [15:0] wa;             // Pending write address
	logic [7:0]  wd;             // Pending write data
	logic        wpend = 1'b0;   // Write waits for strobe release
	logic        rd_act;         // Read strobe asserted
	logic [15:0] addr;           // Address presented now
	// Answer reads at once; only lanes the port has let go are driven
	always @* begin
		rd_act = p1_oe[6] && !p1_out[6];
		addr = {p2_out, latched ? lo_lat : p3_out};
		p4_pin_in = (rd_act && p4_oe === 8'h00) ? mem[addr] : park;
		p3_pin_in = (rd_act && p3_oe === 8'h00) ? mem[addr] : park;
	end
	// Latch low address, capture writes, commit at strobe release
	always @(posedge clk) begin
		park <= ~park;
		if (p1_oe[5] && p1_out[5]) begin
			lo_lat <= p3_out;
			latched <= 1'b1;
		end else if (!p1_oe[6]) begin
			latched <= 1'b0;  // Pads handed back, access over
		end
		if (p1_oe[7] && !p1_out[7]) begin
			wa <= addr;
			wd <= (p4_oe[0] === 1'b1) ? p4_out : p3_out;
			wpend <= 1'b1;
		end else if (wpend) begin
			mem[wa] <= wd;
			wpend <= 1'b0;
		end
	end
endmodule

// *** test_external_memory_port_mapping.sv ***
// Purpose: Self-checking bench for the off-chip memory port.
// Assumes: Default strobe length; port latches parked high.
// Notes:   Expected addresses come from page, latch and mode settings.
`timescale 1ns/1ns
module test_external_memory_port_mapping;
	import emp_pkg::*;
	logic clk = 1'b0, rst = 1'b1;                // Clock and reset
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0;          // Register strobes
	logic acc_start = 1'b0, acc_write = 1'b0, acc_wide = 1'b0;
	logic [15:0] acc_addr = 16'h0000;            // Move address
	logic [7:0] acc_wdata = 8'h00, acc_rdata;    // Move data
	logic acc_busy, acc_done, acc_onchip;        // Move status
	// Latches parked high, pins skipped by crossbar
	logic [7:0] p1_port_out = 8'hff, p1_port_oe = 8'h00;
	logic [7:0] p2_port_out = 8'hff, p2_port_oe = 8'h00;
	logic [7:0] p3_port_out = 8'hff, p3_port_oe = 8'h00;
	logic [7:0] p4_port_out = 8'hff, p4_port_oe = 8'h00;
	logic [7:0] p3_pin_in, p4_pin_in, p1_out, p1_oe, p2_out, p2_oe;
	logic [7:0] p3_out, p3_oe, p4_out, p4_oe, v; // Pads and read value
	logic onc;                                   // On-chip result
	logic lanes_sep = 1'b1;                      // Data on its own lanes
	int fail_count = 0, checks = 0, cyc = 0, ale, claim, bad, bsy;
	emp_offchip_port emp_offchip_port_i (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_start(acc_start),
		.acc_write(acc_write), .acc_wide(acc_wide), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done),
		.acc_onchip(acc_onchip), .acc_rdata(acc_rdata),
		.p1_port_out(p1_port_out), .p1_port_oe(p1_port_oe),
		.p2_port_out(p2_port_out), .p2_port_oe(p2_port_oe),
		.p3_port_out(p3_port_out), .p3_port_oe(p3_port_oe),
		.p4_port_out(p4_port_out), .p4_port_oe(p4_port_oe),
		.p3_pin_in(p3_pin_in), .p4_pin_in(p4_pin_in), .p1_out(p1_out),
		.p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out),
		.p3_oe(p3_oe), .p4_out(p4_out), .p4_oe(p4_oe));
	emp_sram_model emp_sram_model_i (.clk(clk), .p1_out(p1_out),
		.p1_oe(p1_oe), .p2_out(p2_out), .p3_out(p3_out), .p3_oe(p3_oe),
		.p4_out(p4_out), .p4_oe(p4_oe), .p3_pin_in(p3_pin_in),
		.p4_pin_in(p4_pin_in));
	// 100 ns period
	always #50 clk = ~clk;
	// Cut a hang short; all tests need well under this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// One comparison of an 8-bit result
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Unclaimed pads mirror the port latch and crossbar values
	task automatic chk_pads();
		chk8(p1_out, p1_port_out);
		chk8(p1_oe, p1_port_oe);
		chk8(p2_out, p2_port_out);
		chk8(p2_oe, p2_port_oe);
		chk8(p3_out, p3_port_out);
		chk8(p3_oe, p3_port_oe);
		chk8(p4_out, p4_port_out);
		chk8(p4_oe, p4_port_oe);
	endtask
	// Register write: one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Register read: data stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// One move; counts latch cycles, claimed cycles and driven inputs
	task automatic move(input logic w, input logic wide,
		input logic [15:0] a, input logic [7:0] d);
		int i;
		logic done;
		ale = 0;
		claim = 0;
		bad = 0;
		bsy = 0;
		done = 1'b0;
		@(posedge clk);
		acc_start <= 1'b1;
		acc_write <= w;
		acc_wide <= wide;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge clk);
		acc_start <= 1'b0;
		for (i = 0; i < 80 && !done; i++) begin
			#1;
			if (p1_oe[5] === 1'b1 && p1_out[5] === 1'b1) ale++;
			if (p1_oe !== p1_port_oe) claim++;
			if (acc_busy === 1'b1) bsy++;
			if (!w && p1_out[6] === 1'b0
				&& (lanes_sep ? p4_oe : p3_oe) !== 8'h00) bad++;
			done = (acc_done === 1'b1);
			onc = acc_onchip;
			if (!done) @(posedge clk);
		end
		chk8({7'h00, done}, 8'h01);
		if (done) chk_pads();
		chk8({7'h00, acc_busy}, 8'h00);
	endtask
	// Reset values, full page width, masked config, unmapped place
	task automatic t_regs();
		rd(EMP_PAGE_ADDR, v); chk8(v, 8'h00);
		rd(EMP_CFG_ADDR, v); chk8(v, 8'h03);
		rd(8'h55, v); chk8(v, 8'h00);
		wr(EMP_PAGE_ADDR, 8'ha5); rd(EMP_PAGE_ADDR, v); chk8(v, 8'ha5);
		wr(EMP_PAGE_ADDR, 8'h5a); rd(EMP_PAGE_ADDR, v); chk8(v, 8'h5a);
		wr(EMP_CFG_ADDR, 8'hff); rd(EMP_CFG_ADDR, v); chk8(v, 8'h1f);
		$display("test regs done");
	endtask
	// Internal-only mode never claims pads; pads track port values
	task automatic t_onchip();
		wr(EMP_CFG_ADDR, 8'h03);
		move(1'b1, 1'b1, 16'hc321, 8'h11);
		chk8({7'h00, onc}, 8'h01);
		chk8(8'(claim), 8'h00);
		@(posedge clk);
		p1_port_oe <= 8'h1f;
		p3_port_out <= 8'h3c;
		p4_port_oe <= 8'h81;
		repeat (3) @(posedge clk);
		#1 chk_pads();
		@(posedge clk);
		p1_port_oe <= 8'h00;
		p3_port_out <= 8'hff;
		p4_port_oe <= 8'h00;
		repeat (2) @(posedge clk);
		$display("test onchip done");
	endtask
	// Separate lanes: write, read back, no latch strobe
	task automatic t_sep();
		wr(EMP_CFG_ADDR, 8'h1c);
		move(1'b1, 1'b1, 16'h1234, 8'h5e);
		chk8({7'h00, onc}, 8'h00);
		chk8(8'(claim > 0), 8'h01);
		chk8(8'(bsy), 8'(EMP_STROBE_CYC + 1));
		chk8(emp_sram_model_i.mem[16'h1234], 8'h5e);
		chk8(8'(ale), 8'h00);
		move(1'b0, 1'b1, 16'h1234, 8'h00);
		chk8(acc_rdata, 8'h5e);
		chk8(8'(bad), 8'h00);
		$display("test separate done");
	endtask
	// Short moves take the upper byte from the page register
	task automatic t_page();
		wr(EMP_PAGE_ADDR, 8'hff);
		move(1'b1, 1'b0, 16'h0034, 8'hc3);
		chk8(emp_sram_model_i.mem[16'hff34], 8'hc3);
		wr(EMP_PAGE_ADDR, 8'h00);
		move(1'b1, 1'b0, 16'h0034, 8'h3c);
		chk8(emp_sram_model_i.mem[16'h0034], 8'h3c);
		$display("test page done");
	endtask
	// Split modes: 8 kB boundary, latch versus page for upper byte
	task automatic t_split();
		wr(EMP_CFG_ADDR, 8'h14);
		p2_port_out <= 8'h9c;
		move(1'b1, 1'b0, 16'h0077, 8'he1);
		chk8(emp_sram_model_i.mem[16'h9c77], 8'he1);
		move(1'b0, 1'b1, 16'h1fff, 8'h00);
		chk8({7'h00, onc}, 8'h01);
		move(1'b0, 1'b1, 16'h2000, 8'h00);
		chk8({7'h00, onc}, 8'h00);
		p2_port_out <= 8'hff;
		wr(EMP_CFG_ADDR, 8'h18);
		wr(EMP_PAGE_ADDR, 8'h05);
		move(1'b1, 1'b0, 16'h0011, 8'h22);
		chk8({7'h00, onc}, 8'h01);
		wr(EMP_PAGE_ADDR, 8'h40);
		move(1'b1, 1'b0, 16'h0011, 8'h44);
		chk8(emp_sram_model_i.mem[16'h4011], 8'h44);
		$display("test split done");
	endtask
	// Shared lanes: latch width follows field, address before data
	task automatic t_mux();
		lanes_sep = 1'b0;
		wr(EMP_CFG_ADDR, 8'h0e);
		move(1'b1, 1'b1, 16'habcd, 8'h96);
		chk8(8'(ale), 8'h03);
		chk8(8'(bsy), 8'(3 + EMP_HOLD_CYC + EMP_STROBE_CYC + 1));
		chk8(emp_sram_model_i.mem[16'habcd], 8'h96);
		wr(EMP_CFG_ADDR, 8'h0c);
		move(1'b0, 1'b1, 16'habcd, 8'h00);
		chk8(8'(ale), 8'h01);
		chk8(acc_rdata, 8'h96);
		chk8(8'(bad), 8'h00);
		$display("test muxed done");
	endtask
	// Closing report and verdict
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_onchip();
		t_sep();
		t_page();
		t_split();
		t_mux();
		summarize();
	end
endmodule
